// >>> rtl/fpu_operand_exception_detect.v
// Operation
// - Invalid arithmetic operand sets invalid flag, status bit 0.
// - Masked invalid writes indefinite or quiet NaN, or sets codes.
// - Unmasked invalid requests handler; stack pointer, sources held.
// - Unsupported encoding is invalid; masked result is NaN indefinite.
// - Signaling NaN operand is invalid; masked result is quieted NaN.
// - Ordered compare with NaN, masked, sets codes to 111 unordered.
// - Infinity sums, inf*0, inf/inf, 0/0 invalid; indefinite returned.
// - Remainder by zero or of infinity invalid; indefinite, code2 cleared.
// - Trig on infinity invalid; indefinite returned, code2 cleared.
// - Negative sqrt, log2 operand, log-plus-one below -1 invalid.
// - Packed-decimal store overflow or special source stores indefinite.
// - Integer store overflow or special source stores integer indefinite.
// - Exchange with empty register fills indefinite, then exchanges.
// - Quiet NaN alone normally raises no invalid exception.
// - Ordered compares and integer conversions flag quiet NaN invalid.
// - Denormal arithmetic operand or narrow denormal load raises denormal.
// - Denormal flag is status bit 1, its mask control bit 1.
// - Masked denormal sets flag, continues, normalizes narrow denormal.
// - Unmasked denormal sets flag, requests handler, holds state.
// - Finite nonzero divided by zero flags divide-by-zero, bit 2.
// - Unmasked divide-by-zero sets flag, requests handler, holds state.
// - Masked divide-by-zero returns signed infinity per operation.
// - Exponent extract of zero gives -inf second, signed zero top.
// - Invalid mask is control bit 0; set selects masked response.
// - Invalid arithmetic operand leaves the stack-fault flag alone.
`timescale 1ns/1ps
`include "fpu_exc_defines.vh"

module fpu_operand_exception_detect (
  input  wire        clock,
  input  wire        rst,
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire [79:0] operand_a,
  input  wire [79:0] operand_b,
  input  wire        a_empty,
  input  wire        b_empty,
  input  wire [63:0] mem_raw,
  input  wire [1:0]  load_fmt,
  input  wire [1:0]  int_width,
  input  wire        conv_range_ovf,
  input  wire [15:0] control_word,
  input  wire        flags_clear,
  input  wire        stack_fault_set,
  output reg         done_r,
  output reg         proceed_r,
  output reg         handler_req_r,
  output reg         hold_state_r,
  output reg         normalize_req_r,
  output reg         dest_wr_r,
  output reg  [79:0] dest_value_r,
  output reg         second_wr_r,
  output reg  [79:0] second_value_r,
  output reg         cc_wr_r,
  output reg         proc_flags_wr_r,
  output reg         cond_code_0_r,
  output reg         cond_code_2_r,
  output reg         cond_code_3_r,
  output reg  [6:0]  status_word_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Operand classification

  wire [159:0] opnd_bus;
  wire [1:0]   sgn;
  wire [1:0]   zro;
  wire [1:0]   den;
  wire [1:0]   inf;
  wire [1:0]   snan;
  wire [1:0]   qnan;
  wire [1:0]   unsup;

  assign opnd_bus = {operand_b, operand_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_cls
      fpu_operand_classify u_cls (
        .value     (opnd_bus[gi*80 +: 80]),
        .sign      (sgn[gi]),
        .is_zero   (zro[gi]),
        .is_denorm (den[gi]),
        .is_inf    (inf[gi]),
        .is_snan   (snan[gi]),
        .is_qnan   (qnan[gi]),
        .is_unsup  (unsup[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode

  wire invalid_op_mask;
  wire denormal_mask;
  wire divzero_mask;
  wire uses_b;
  wire is_arith;
  wire is_conv;
  wire ord_cmp;
  wire any_cmp;
  wire narrow_den;

  assign invalid_op_mask = control_word[`MASK_INV_BIT];
  assign denormal_mask   = control_word[`MASK_DEN_BIT];
  assign divzero_mask    = control_word[`MASK_DZ_BIT];

  assign uses_b = (op_code == `OP_ADD) || (op_code == `OP_SUB)
               || (op_code == `OP_MUL) || (op_code == `OP_DIV)
               || (op_code == `OP_CMP) || (op_code == `OP_UCMP)
               || (op_code == `OP_CMPI) || (op_code == `OP_PREM)
               || (op_code == `OP_LOG2) || (op_code == `OP_LOG2P1);
  // Exchange and load are screened by their own logic
  assign is_arith = (op_code != `OP_XCH) && (op_code != `OP_LOAD);
  assign is_conv  = (op_code == `OP_BCD_ST) || (op_code == `OP_INT_ST);
  assign ord_cmp  = (op_code == `OP_CMP) || (op_code == `OP_CMPI)
                 || (op_code == `OP_TEST);
  assign any_cmp  = ord_cmp || (op_code == `OP_UCMP);

  // Narrow denormals seen before widening
  assign narrow_den =
    ((load_fmt == `FMT_SINGLE) && (mem_raw[30:23] == 8'h00)
      && (mem_raw[22:0] != 23'h00_0000))
    || ((load_fmt == `FMT_DOUBLE) && (mem_raw[62:52] == 11'h000)
      && (mem_raw[51:0] != 52'h0_0000_0000_0000));

  wire a_snan;
  wire a_qnan;
  wire a_unsup;
  wire a_nan;
  wire b_snan;
  wire b_unsup;
  wire b_nan;
  wire a_fin_nz;
  wire lp1_low;

  assign a_snan   = snan[0];
  assign a_qnan   = qnan[0];
  assign a_unsup  = unsup[0];
  assign a_nan    = snan[0] || qnan[0];
  assign b_snan   = uses_b && snan[1];
  assign b_unsup  = uses_b && unsup[1];
  assign b_nan    = uses_b && (snan[1] || qnan[1]);
  assign a_fin_nz = !zro[0] && !inf[0] && !a_nan && !a_unsup;
  // Magnitude above one with negative sign
  assign lp1_low  = sgn[0] && !a_nan && (inf[0]
    || (operand_a[78:64] > `EXP_ONE)
    || ((operand_a[78:64] == `EXP_ONE)
        && (operand_a[63:0] > `ONE_MANT)));

  ////////////////////////////////////////////////////////////////////////////
  // Exception detection and default responses

  reg        inv_c;
  reg        den_c;
  reg        dz_c;
  reg        wr_c;
  reg [79:0] val_c;
  reg        sec_wr_c;
  reg [79:0] sec_c;
  reg        cc_c;
  reg        c2_only_c;
  reg [79:0] conv_indef;
  reg [79:0] snan_q;

  always @*
  begin
    inv_c      = 1'b0;
    den_c      = 1'b0;
    dz_c       = 1'b0;
    wr_c       = 1'b0;
    val_c      = `QNAN_INDEF;
    sec_wr_c   = 1'b0;
    sec_c      = `QNAN_INDEF;
    cc_c       = 1'b0;
    c2_only_c  = 1'b0;
    snan_q     = a_snan ? operand_a : operand_b;
    snan_q[`QUIET_BIT] = 1'b1;
    case (int_width)
      `INT_W16: conv_indef = `INT16_INDEF;
      `INT_W32: conv_indef = `INT32_INDEF;
      default:  conv_indef = `INT64_INDEF;
    endcase
    if (op_code == `OP_BCD_ST)
      conv_indef = `BCD_INDEF;

    if (is_arith && (a_unsup || b_unsup))
    begin
      inv_c = 1'b1;
      wr_c  = !any_cmp;
    end
    else if (is_arith && (a_snan || b_snan))
    begin
      inv_c = 1'b1;
      wr_c  = !any_cmp;
      val_c = snan_q;
    end
    // Quiet NaNs pass except for ordered compares and conversions
    else if ((ord_cmp || is_conv) && (a_nan || b_nan))
      inv_c = 1'b1;
    else if (is_arith && (a_nan || b_nan))
      inv_c = 1'b0;
    else
    begin
      case (op_code)
        `OP_ADD:    inv_c = inf[0] && inf[1] && (sgn[0] != sgn[1]);
        `OP_SUB:    inv_c = inf[0] && inf[1] && (sgn[0] == sgn[1]);
        `OP_MUL:    inv_c = (inf[0] && zro[1]) || (zro[0] && inf[1]);
        `OP_DIV:
        begin
          inv_c = (inf[0] && inf[1]) || (zro[0] && zro[1]);
          dz_c  = a_fin_nz && zro[1];
          val_c = `INF_POS;
          val_c[79] = sgn[0] ^ sgn[1];
        end
        `OP_PREM:
        begin
          inv_c     = zro[1] || inf[0];
          c2_only_c = inv_c;
        end
        `OP_TRIG:
        begin
          inv_c     = inf[0];
          c2_only_c = inv_c;
        end
        `OP_SQRT:   inv_c = sgn[0] && !zro[0];
        `OP_LOG2:
        begin
          inv_c = sgn[0] && !zro[0];
          dz_c  = zro[0] && !zro[1] && !inf[1];
          val_c = `INF_POS;
          val_c[79] = !sgn[1];
        end
        `OP_LOG2P1: inv_c = lp1_low;
        `OP_BCD_ST: inv_c = conv_range_ovf || inf[0];
        `OP_INT_ST: inv_c = conv_range_ovf || inf[0];
        `OP_XCH:
        begin
          inv_c    = a_empty || b_empty;
          val_c    = b_empty ? `QNAN_INDEF : operand_b;
          sec_c    = a_empty ? `QNAN_INDEF : operand_a;
          sec_wr_c = inv_c;
        end
        `OP_XTRACT:
        begin
          dz_c  = zro[0];
          val_c = `VALUE_RST;
          val_c[79] = sgn[0];
          sec_c = `INF_POS;
          sec_c[79] = 1'b1;
          sec_wr_c = dz_c;
        end
        default:    inv_c = 1'b0;
      endcase
      if (inv_c && (op_code != `OP_XCH))
        val_c = `QNAN_INDEF;
      wr_c = inv_c && !ord_cmp;
    end

    if (is_conv && inv_c)
    begin
      val_c = conv_indef;
      wr_c  = 1'b1;
    end
    if (ord_cmp && inv_c)
      cc_c = 1'b1;

    // Invalid takes precedence over denormal, unmasked denormal over divide
    den_c = !inv_c && ((op_code == `OP_LOAD) ? narrow_den
            : (is_arith && (den[0] || (uses_b && den[1]))));
    if (inv_c || (den_c && !denormal_mask))
      dz_c = 1'b0;
    if (dz_c && !(op_code == `OP_XTRACT))
      sec_wr_c = 1'b0;
    if (dz_c)
      wr_c = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response registers

  wire fire;
  wire stop;
  wire masked;

  assign fire   = op_valid;
  assign stop   = (inv_c && !invalid_op_mask) || (den_c && !denormal_mask)
               || (dz_c && !divzero_mask);
  assign masked = fire && !stop;

  always @(posedge clock)
  begin
    if (rst)
    begin
      done_r          <= 1'b0;
      proceed_r       <= 1'b0;
      handler_req_r   <= 1'b0;
      hold_state_r    <= 1'b0;
      normalize_req_r <= 1'b0;
      dest_wr_r       <= 1'b0;
      dest_value_r    <= `VALUE_RST;
      second_wr_r     <= 1'b0;
      second_value_r  <= `VALUE_RST;
      cc_wr_r         <= 1'b0;
      proc_flags_wr_r <= 1'b0;
      cond_code_0_r   <= 1'b0;
      cond_code_2_r   <= 1'b0;
      cond_code_3_r   <= 1'b0;
    end
    else
    begin
      done_r        <= fire;
      // Unmasked: no write at all, so the handler sees the sources intact
      handler_req_r <= fire && stop;
      hold_state_r  <= fire && stop;
      // Masked denormal lets the datapath carry on with the normal result
      proceed_r     <= masked && !inv_c && !dz_c;
      normalize_req_r <= masked && den_c && (op_code == `OP_LOAD);
      dest_wr_r     <= masked && wr_c;
      second_wr_r   <= masked && sec_wr_c;
      if (fire)
      begin
        dest_value_r   <= val_c;
        second_value_r <= sec_c;
      end
      cc_wr_r <= masked && (cc_c || c2_only_c) && (op_code != `OP_CMPI);
      proc_flags_wr_r <= masked && cc_c && (op_code == `OP_CMPI);
      if (masked && cc_c)
      begin
        cond_code_0_r <= 1'b1;
        cond_code_2_r <= 1'b1;
        cond_code_3_r <= 1'b1;
      end
      else if (masked && c2_only_c)
        cond_code_2_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, set wins over clear

  wire [6:0] set_vec;

  assign set_vec = {stack_fault_set, 3'b000,
                    fire && dz_c, fire && den_c, fire && inv_c};

  always @(posedge clock)
  begin
    if (rst)
      status_word_r <= `STATUS_RST;
    else
    begin
      // Invalid never touches bit 6; only a stack fault sets it
      status_word_r <= (flags_clear ? 7'h00 : status_word_r)
                       | set_vec;
    end
  end

endmodule // fpu_operand_exception_detect

// >>> rtl/fpu_exc_defines.vh
`ifndef FPU_EXC_DEFINES_VH
`define FPU_EXC_DEFINES_VH

// Operation codes from the sequencer
`define OP_ADD        5'h00
`define OP_SUB        5'h01
`define OP_MUL        5'h02
`define OP_DIV        5'h03
`define OP_CMP        5'h04
`define OP_UCMP       5'h05
`define OP_CMPI       5'h06
`define OP_TEST       5'h07
`define OP_PREM       5'h08
`define OP_TRIG       5'h09
`define OP_SQRT       5'h0a
`define OP_LOG2       5'h0b
`define OP_LOG2P1     5'h0c
`define OP_BCD_ST     5'h0d
`define OP_INT_ST     5'h0e
`define OP_XCH        5'h0f
`define OP_XTRACT     5'h10
`define OP_LOAD       5'h11

// Status and control word bit positions
`define FLAG_INV_BIT  0
`define FLAG_DEN_BIT  1
`define FLAG_DZ_BIT   2
`define FLAG_SF_BIT   6
`define MASK_INV_BIT  0
`define MASK_DEN_BIT  1
`define MASK_DZ_BIT   2

// Reset values
`define STATUS_RST    7'h00
`define VALUE_RST     80'h0000_0000_0000_0000_0000

// Memory load formats
`define FMT_SINGLE    2'h0
`define FMT_DOUBLE    2'h1
`define FMT_EXTENDED  2'h2

// Integer store widths
`define INT_W16       2'h0
`define INT_W32       2'h1
`define INT_W64       2'h2

// Default values
`define QNAN_INDEF    80'hffff_c000_0000_0000_0000
`define BCD_INDEF     80'hffff_c000_0000_0000_0000
`define INT16_INDEF   80'h0000_0000_0000_0000_8000
`define INT32_INDEF   80'h0000_0000_0000_8000_0000
`define INT64_INDEF   80'h0000_8000_0000_0000_0000
`define INF_POS       80'h7fff_8000_0000_0000_0000
`define ONE_MANT      64'h8000_0000_0000_0000
`define EXP_MAX       15'h7fff
`define EXP_ONE       15'h3fff
`define QUIET_BIT     62

`endif

// >>> rtl/fpu_operand_classify.v
`timescale 1ns/1ps
`include "fpu_exc_defines.vh"

module fpu_operand_classify (
  input  wire [79:0] value,
  output wire        sign,
  output wire        is_zero,
  output wire        is_denorm,
  output wire        is_inf,
  output wire        is_snan,
  output wire        is_qnan,
  output wire        is_unsup
);

  wire [14:0] expo;
  wire [63:0] mant;
  wire        jbit;
  wire        top_e;

  assign expo  = value[78:64];
  assign mant  = value[63:0];
  assign jbit  = mant[63];
  assign top_e = (expo == `EXP_MAX);
  assign sign  = value[79];

  assign is_zero   = (expo == 15'h0000) && (mant == 64'h0000_0000_0000_0000);
  // Pseudo-denormals fall here too
  assign is_denorm = (expo == 15'h0000) && (mant != 64'h0000_0000_0000_0000);
  assign is_inf    = top_e && (mant == `ONE_MANT);
  assign is_qnan   = top_e && jbit && mant[`QUIET_BIT];
  assign is_snan   = top_e && jbit && !mant[`QUIET_BIT]
                     && (mant[61:0] != 62'h0);
  // Unnormals, pseudo-NaN and pseudo-infinity have a clear integer bit
  assign is_unsup  = (expo != 15'h0000) && !jbit;

endmodule // fpu_operand_classify

// >>> dv/fpu_stack_model.sv
`timescale 1ns/1ps

module fpu_stack_model (
  input  wire        clock,
  input  wire        rst,
  input  wire        dest_wr_r,
  input  wire        hold_state_r,
  input  wire [79:0] dest_value_r,
  output reg  [79:0] top_r
);
  // Top moves only on a real write; a held op must leave it alone
  always @(posedge clock)
  begin
    if (rst)
      top_r <= 80'h0000_0000_0000_0000_0000;
    else if (dest_wr_r && !hold_state_r)
      top_r <= dest_value_r;
  end
endmodule // fpu_stack_model

// >>> dv/fpu_operand_exception_detect_assertions.sv
`timescale 1ns/1ps
`include "fpu_exc_defines.vh"

module fpu_exc_checker (
  input wire        clock,
  input wire        rst,
  input wire        op_valid,
  input wire [4:0]  op_code,
  input wire [79:0] operand_a,
  input wire [79:0] operand_b,
  input wire [15:0] control_word,
  input wire        flags_clear,
  input wire        stack_fault_set,
  input wire        handler_req_r,
  input wire        dest_wr_r,
  input wire        second_wr_r,
  input wire [79:0] dest_value_r,
  input wire        cc_wr_r,
  input wire        cond_code_0_r,
  input wire        cond_code_2_r,
  input wire        cond_code_3_r,
  input wire        normalize_req_r,
  input wire [6:0]  status_word_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  wire nrm_b = operand_b[78:64] == 15'h3fff && operand_b[63];
  wire div0 = op_valid && op_code == `OP_DIV && operand_b[78:0] == 79'h0
              && operand_a[78:64] == 15'h3fff && operand_a[63];
  wire den_a = operand_a[78:63] == 16'h0000 && operand_a[62:0] != 63'h0;
  wire qn_a = operand_a[78:62] == 17'h1_ffff;
  wire inf_sum = op_valid && op_code == `OP_ADD
                 && operand_a[78:0] == 79'h7fff_8000_0000_0000_0000
                 && operand_b[78:0] == 79'h7fff_8000_0000_0000_0000
                 && operand_a[79] != operand_b[79];
  ////////////////////////////////////////////////////////////////////////////
  property p_inv_flag; inf_sum |=> status_word_r[0]; endproperty
  a_inv_flag: assert property (p_inv_flag)
    else $error("invalid flag not set");
  property p_inv_mask;
    inf_sum && control_word[0] |=> dest_wr_r && dest_value_r == `QNAN_INDEF;
  endproperty
  a_inv_mask: assert property (p_inv_mask)
    else $error("masked invalid result wrong");
  property p_inv_unm;
    inf_sum && !control_word[0] |=> handler_req_r && !dest_wr_r;
  endproperty
  a_inv_unm: assert property (p_inv_unm)
    else $error("unmasked invalid not held");
  property p_hold;
    handler_req_r |-> !dest_wr_r && !second_wr_r && !cc_wr_r;
  endproperty
  a_hold: assert property (p_hold)
    else $error("write during handler request");
  property p_dz_flag; div0 |=> status_word_r[2]; endproperty
  a_dz_flag: assert property (p_dz_flag)
    else $error("divide by zero flag not set");
  property p_dz_mask;
    div0 && control_word[2] |=> dest_wr_r && dest_value_r ==
      {$past(operand_a[79]) ^ $past(operand_b[79]),
       79'h7fff_8000_0000_0000_0000};
  endproperty
  a_dz_mask: assert property (p_dz_mask)
    else $error("divide by zero infinity wrong");
  property p_den;
    op_valid && op_code == `OP_ADD && den_a && nrm_b && control_word[0]
      |=> status_word_r[1] && handler_req_r == !$past(control_word[1]);
  endproperty
  a_den: assert property (p_den)
    else $error("denormal response wrong");
  property p_cmp_nan;
    op_valid && op_code == `OP_CMP && qn_a && control_word[0]
      |=> cc_wr_r && {cond_code_3_r, cond_code_2_r, cond_code_0_r} == 3'b111;
  endproperty
  a_cmp_nan: assert property (p_cmp_nan)
    else $error("unordered codes wrong");
  property p_sticky;
    !flags_clear |=> (status_word_r & $past(status_word_r))
      == $past(status_word_r);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status flag dropped");
  property p_sf_keep;
    !stack_fault_set && !flags_clear |=> $stable(status_word_r[6]);
  endproperty
  a_sf_keep: assert property (p_sf_keep)
    else $error("stack fault flag changed");
  cover property (handler_req_r);
  cover property (cc_wr_r);
  cover property (normalize_req_r);
endmodule // fpu_exc_checker

bind fpu_operand_exception_detect fpu_exc_checker chk (
  .clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code),
  .operand_a(operand_a), .operand_b(operand_b),
  .control_word(control_word), .flags_clear(flags_clear),
  .stack_fault_set(stack_fault_set), .handler_req_r(handler_req_r),
  .dest_wr_r(dest_wr_r), .second_wr_r(second_wr_r),
  .dest_value_r(dest_value_r), .cc_wr_r(cc_wr_r),
  .cond_code_0_r(cond_code_0_r), .cond_code_2_r(cond_code_2_r),
  .cond_code_3_r(cond_code_3_r), .normalize_req_r(normalize_req_r),
  .status_word_r(status_word_r));

// >>> dv/test_fpu_operand_exception_detect.sv
`timescale 1ns/1ps
`include "fpu_exc_defines.vh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end

module test_fpu_operand_exception_detect;
  localparam [79:0] ONE  = 80'h3fff_8000_0000_0000_0000;
  localparam [79:0] MONE = 80'hbfff_8000_0000_0000_0000;
  localparam [79:0] NINF = 80'hffff_8000_0000_0000_0000;
  localparam [79:0] SNAN = 80'h7fff_a000_0000_0000_0000;
  localparam [79:0] QNAN = 80'h7fff_c000_0000_0000_0001;
  localparam [79:0] DEN  = 80'h0000_0000_0000_0000_0001;
  localparam [79:0] BAD  = 80'h3fff_0000_0000_0000_0000;
  localparam [79:0] Z    = 80'h0000_0000_0000_0000_0000;
  localparam [15:0] M    = 16'h0007;
  reg        clock, rst, op_valid, a_empty, b_empty, conv_range_ovf;
  reg        flags_clear, stack_fault_set;
  reg [4:0]  op_code;
  reg [79:0] operand_a, operand_b, snap;
  reg [63:0] mem_raw;
  reg [1:0]  load_fmt, int_width;
  reg [15:0] control_word;
  wire       done_r, proceed_r, handler_req_r, hold_state_r, dest_wr_r;
  wire       normalize_req_r, second_wr_r, cc_wr_r, proc_flags_wr_r;
  wire       cond_code_0_r, cond_code_2_r, cond_code_3_r;
  wire [79:0] dest_value_r, second_value_r, top_r;
  wire [6:0] status_word_r;
  wire [2:0] codes = {cond_code_3_r, cond_code_2_r, cond_code_0_r};
  int        n_fail, n_tests, cycles;
  ////////////////////////////////////////////////////////////////////////////
  fpu_operand_exception_detect uut (
    .clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .operand_a(operand_a), .operand_b(operand_b), .a_empty(a_empty),
    .b_empty(b_empty), .mem_raw(mem_raw), .load_fmt(load_fmt),
    .int_width(int_width), .conv_range_ovf(conv_range_ovf),
    .control_word(control_word), .flags_clear(flags_clear),
    .stack_fault_set(stack_fault_set), .done_r(done_r),
    .proceed_r(proceed_r), .handler_req_r(handler_req_r),
    .hold_state_r(hold_state_r), .normalize_req_r(normalize_req_r),
    .dest_wr_r(dest_wr_r), .dest_value_r(dest_value_r),
    .second_wr_r(second_wr_r), .second_value_r(second_value_r),
    .cc_wr_r(cc_wr_r), .proc_flags_wr_r(proc_flags_wr_r),
    .cond_code_0_r(cond_code_0_r), .cond_code_2_r(cond_code_2_r),
    .cond_code_3_r(cond_code_3_r), .status_word_r(status_word_r));
  fpu_stack_model far (.clock(clock), .rst(rst), .dest_wr_r(dest_wr_r),
    .hold_state_r(hold_state_r), .dest_value_r(dest_value_r), .top_r(top_r));
  ////////////////////////////////////////////////////////////////////////////
  task t(input [4:0] c, input [79:0] a, input [79:0] b, input [15:0] cw);
  begin
    @(posedge clock);
    op_code <= c;
    operand_a <= a;
    operand_b <= b;
    control_word <= cw;
    op_valid <= 1'b1;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  end
  endtask
  task e(input h, input w, input [79:0] v, input [2:0] s);
  begin
    `CHK("handler", h, handler_req_r)
    `CHK("hold", h, hold_state_r)
    `CHK("done", 1'b1, done_r)
    `CHK("dest_wr", w, dest_wr_r)
    if (w) `CHK("dest", v, dest_value_r)
    `CHK("flags", s, status_word_r[2:0])
  end
  endtask
  task pulse(input sf);
  begin
    @(posedge clock);
    flags_clear <= !sf;
    stack_fault_set <= sf;
    @(posedge clock);
    flags_clear <= 1'b0;
    stack_fault_set <= 1'b0;
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  // Ceiling well above the fewer than a hundred cycles the tests need
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      conclude;
    end
  end
  initial
  begin
    {rst, op_valid, a_empty, b_empty, conv_range_ovf} = 5'b1_0000;
    {flags_clear, stack_fault_set, op_code, load_fmt, int_width} = 0;
    {operand_a, operand_b, mem_raw, control_word} = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t(`OP_DIV, ONE, Z, M); e(0, 1, `INF_POS, 3'b100);
    t(`OP_DIV, MONE, Z, M); e(0, 1, NINF, 3'b100);
    t(`OP_LOG2, Z, ONE, M); e(0, 1, NINF, 3'b100);
    t(`OP_XTRACT, 80'h8000_0000_0000_0000_0000, Z, M);
    e(0, 1, 80'h8000_0000_0000_0000_0000, 3'b100);
    `CHK("second", NINF, second_value_r)
    `CHK("second_wr", 1'b1, second_wr_r)
    t(`OP_ADD, ONE, ONE, M); e(0, 0, Z, 3'b100);
    `CHK("proceed", 1'b1, proceed_r)
    pulse(0);
    snap = top_r;
    t(`OP_DIV, ONE, Z, 16'h0000); e(1, 0, Z, 3'b100);
    @(posedge clock);
    #1;
    `CHK("top held", snap, top_r)
    $display("test divide by zero done");
    pulse(0);
    t(`OP_ADD, `INF_POS, NINF, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_ADD, `INF_POS, NINF, 16'h0006); e(1, 0, Z, 3'b001);
    t(`OP_SUB, NINF, NINF, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_MUL, `INF_POS, Z, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_DIV, Z, Z, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_DIV, NINF, NINF, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_ADD, BAD, ONE, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_ADD, SNAN, ONE, M);
    e(0, 1, 80'h7fff_e000_0000_0000_0000, 3'b001);
    t(`OP_SQRT, MONE, Z, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_LOG2P1, 80'hc000_8000_0000_0000_0000, Z, M);
    e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_CMP, QNAN, ONE, M); e(0, 0, Z, 3'b001);
    `CHK("codes", 3'b111, codes)
    t(`OP_CMPI, ONE, QNAN, M); `CHK("processor_flags_reg", 1'b1, proc_flags_wr_r)
    t(`OP_PREM, ONE, Z, M); e(0, 1, `QNAN_INDEF, 3'b001);
    `CHK("code2", 1'b0, cond_code_2_r)
    t(`OP_TRIG, `INF_POS, Z, M); e(0, 1, `QNAN_INDEF, 3'b001);
    t(`OP_TEST, QNAN, Z, M); e(0, 0, Z, 3'b001);
    `CHK("test codes", 3'b111, codes)
    @(posedge clock);
    {conv_range_ovf, int_width} <= {1'b1, `INT_W32};
    t(`OP_INT_ST, ONE, Z, M); e(0, 1, `INT32_INDEF, 3'b001);
    t(`OP_BCD_ST, QNAN, Z, M); e(0, 1, `BCD_INDEF, 3'b001);
    @(posedge clock);
    a_empty <= 1'b1;
    t(`OP_XCH, Z, ONE, M); e(0, 1, ONE, 3'b001);
    `CHK("xch second", `QNAN_INDEF, second_value_r)
    `CHK("xch second_wr", 1'b1, second_wr_r)
    pulse(0);
    t(`OP_UCMP, QNAN, ONE, M); e(0, 0, Z, 3'b000);
    pulse(1);
    t(`OP_ADD, SNAN, ONE, 16'h0006); e(1, 0, Z, 3'b001);
    `CHK("stack fault", 1'b1, status_word_r[6])
    $display("test invalid operand done");
    pulse(0);
    t(`OP_ADD, DEN, ONE, M); e(0, 0, Z, 3'b010);
    `CHK("den proceed", 1'b1, proceed_r)
    t(`OP_ADD, DEN, ONE, 16'h0005); e(1, 0, Z, 3'b010);
    pulse(0);
    {mem_raw, load_fmt} <= {64'h0000_0000_0000_0001, `FMT_EXTENDED};
    t(`OP_LOAD, Z, Z, M); e(0, 0, Z, 3'b000);
    @(posedge clock);
    load_fmt <= `FMT_SINGLE;
    t(`OP_LOAD, Z, Z, M); e(0, 0, Z, 3'b010);
    `CHK("normalize", 1'b1, normalize_req_r)
    pulse(0);
    load_fmt <= `FMT_DOUBLE;
    t(`OP_LOAD, Z, Z, M); e(0, 0, Z, 3'b010);
    $display("test denormal done");
    conclude;
  end
endmodule // test_fpu_operand_exception_detect
